// file: hw/sscone_pkg.sv
// Package: register map and field layout of the serial control block
package sscone_pkg;

  // ==========================================================
  // Register map
  localparam logic [11:0] SSCONE_OFF_CTRL1   = 12'h004;
  localparam logic [11:0] SSCONE_OFF_STATUS  = 12'h010;
  localparam logic [11:0] SSCONE_ADDR_MASK   = 12'hffc;

  // ==========================================================
  // Field positions of serial_control_one
  localparam int SSCONE_LOOPBACK_BIT = 0;
  localparam int SSCONE_ENABLE_BIT   = 1;
  localparam int SSCONE_ROLE_BIT     = 2;
  localparam int SSCONE_SOD_BIT      = 3;
  localparam int SSCONE_CTRL_WIDTH   = 4;

  localparam logic [3:0]  SSCONE_CTRL_RESET = 4'h0;
  localparam logic [31:0] SSCONE_ZERO_WORD  = 32'h0000_0000;

  // ==========================================================
  // Status fields (own register)
  localparam int SSCONE_ST_RUNNING_BIT = 0;
  localparam int SSCONE_ST_TXDRV_BIT   = 1;
  localparam int SSCONE_ST_LOOP_BIT    = 2;
  localparam int SSCONE_ST_BLOCKED_BIT = 3;

  typedef enum logic {
    SSCONE_MASTER = 1'b0,
    SSCONE_SLAVE  = 1'b1
  } sscone_role_type;

endpackage

// file: hw/sscone_route_if.sv
// Interface: control fields carried from register file to the routing module
interface sscone_route_if;
  logic enable;
  logic loopback;
  logic role;
  logic slave_output_disable;

  modport regs  (output enable, output loopback, output role, output slave_output_disable);
  modport route (input enable, input loopback, input role, input slave_output_disable);
endinterface

// file: hw/sscone_route.sv
// Module: serial datapath routing for loopback, enable and slave output gate
module sscone_route
  import sscone_pkg::*;
(
  // Clock and reset
  input  wire logic   pclk,
  input  wire logic   presetn,
  // Control fields
  sscone_route_if.route ctl,
  // Shifter side
  input  wire logic   shift_tx_bit,
  input  wire logic   shift_tx_active,
  output logic        shift_rx_bit,
  output logic        shift_run,
  // Pin side
  input  wire logic   serial_rx_in,
  output logic        serial_tx_out,
  output logic        serial_tx_oe
);

  // ==========================================================
  // Input synchroniser for the receive pin
  logic rx_meta_reg;
  logic rx_sync_reg;
  logic rx_meta_next;
  logic rx_sync_next;

  always_comb begin
    rx_meta_next = serial_rx_in;
    rx_sync_next = rx_meta_reg;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_meta_reg <= 1'b0;
      rx_sync_reg <= 1'b0;
    end else begin
      rx_meta_reg <= rx_meta_next;
      rx_sync_reg <= rx_sync_next;
    end
  end

  // ==========================================================
  // Output stage, registered
  logic tx_reg;
  logic tx_next;
  logic oe_reg;
  logic oe_next;

  always_comb begin
    tx_next = 1'b0;
    oe_next = 1'b0;
    if (ctl.enable && !ctl.loopback) begin // RULE1 RULE5
      tx_next = shift_tx_bit;
      oe_next = shift_tx_active;
      if ((ctl.role == SSCONE_SLAVE) && ctl.slave_output_disable) begin
        oe_next = 1'b0; // RULE6
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_reg <= 1'b0;
      oe_reg <= 1'b0;
    end else begin
      tx_reg <= tx_next;
      oe_reg <= oe_next;
    end
  end

  // Loopback never reaches the pin, so the line stays quiet in test mode
  assign shift_rx_bit  = ctl.loopback ? shift_tx_bit : rx_sync_reg; // RULE3 RULE4 RULE5
  assign shift_run     = ctl.enable; // RULE1
  assign serial_tx_out = tx_reg;
  assign serial_tx_oe  = oe_reg;

endmodule

// file: hw/sscone_top.sv
// Module: control register one of the synchronous serial port, APB slave
// Behaviour
// RULE1: The port runs only while the port-enable bit is set; clearing it stops all operation.
// RULE2: Software clears the port-enable bit before rewriting any control field.
// RULE3: Setting the loopback select bit at bit zero places the port in loopback test mode.
// RULE4: In loopback the transmit shifter output feeds the receive shifter input internally.
// RULE5: With loopback clear the port works normally with no internal transmit-to-receive path.
// RULE6: A slave with slave-output disable set leaves its transmit output undriven.
// RULE7: Clearing the port-enable bit does not flush the transmit or receive FIFO.
module sscone_top
  import sscone_pkg::*;
(
  // APB
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Shifter side
  input  wire logic        shift_tx_bit,
  input  wire logic        shift_tx_active,
  output logic             shift_rx_bit,
  output logic             shift_run,
  output logic             fifo_flush,
  output logic             role_slave,
  // Serial pins
  input  wire logic        serial_rx_in,
  output logic             serial_tx_out,
  output logic             serial_tx_oe
);

  // ==========================================================
  // Bus decode
  logic        access;
  logic        hit_ctrl;
  logic        hit_status;
  logic [11:0] word_addr;

  assign word_addr  = paddr & SSCONE_ADDR_MASK;
  assign access     = psel && penable;
  assign hit_ctrl   = (word_addr == SSCONE_OFF_CTRL1);
  assign hit_status = (word_addr == SSCONE_OFF_STATUS);

  // ==========================================================
  // Control register
  logic [SSCONE_CTRL_WIDTH-1:0] ctrl_reg;
  logic [SSCONE_CTRL_WIDTH-1:0] ctrl_next;
  logic                         blocked_reg;
  logic                         blocked_next;
  logic                         wr_ctrl;
  logic                         field_change;
  logic                         enabled_now;

  assign wr_ctrl     = access && pwrite && hit_ctrl && pstrb[0];
  assign enabled_now = ctrl_reg[SSCONE_ENABLE_BIT];
  // Any change to a field other than the enable bit itself
  assign field_change =
    (pwdata[SSCONE_LOOPBACK_BIT] != ctrl_reg[SSCONE_LOOPBACK_BIT]) ||
    (pwdata[SSCONE_ROLE_BIT]     != ctrl_reg[SSCONE_ROLE_BIT])     ||
    (pwdata[SSCONE_SOD_BIT]      != ctrl_reg[SSCONE_SOD_BIT]);

  always_comb begin
    ctrl_next    = ctrl_reg;
    blocked_next = blocked_reg;
    if (wr_ctrl) begin
      if (enabled_now && field_change) begin
        // Reconfiguring a running port is refused; only enable may change
        ctrl_next[SSCONE_ENABLE_BIT] = pwdata[SSCONE_ENABLE_BIT]; // RULE2
        blocked_next                 = 1'b1;
      end else begin
        ctrl_next    = pwdata[SSCONE_CTRL_WIDTH-1:0]; // RULE3
        blocked_next = 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg    <= SSCONE_CTRL_RESET;
      blocked_reg <= 1'b0;
    end else begin
      ctrl_reg    <= ctrl_next;
      blocked_reg <= blocked_next;
    end
  end

  // ==========================================================
  // Routing
  sscone_route_if rif ();

  assign rif.enable   = ctrl_reg[SSCONE_ENABLE_BIT];
  assign rif.loopback = ctrl_reg[SSCONE_LOOPBACK_BIT];
  assign rif.role     = ctrl_reg[SSCONE_ROLE_BIT];
  assign rif.slave_output_disable      = ctrl_reg[SSCONE_SOD_BIT];

  sscone_route u_route (
    .pclk            (pclk),
    .presetn         (presetn),
    .ctl             (rif.route),
    .shift_tx_bit    (shift_tx_bit),
    .shift_tx_active (shift_tx_active),
    .shift_rx_bit    (shift_rx_bit),
    .shift_run       (shift_run),
    .serial_rx_in    (serial_rx_in),
    .serial_tx_out   (serial_tx_out),
    .serial_tx_oe    (serial_tx_oe)
  );

  // FIFO contents survive disable so software can preload transmit data
  assign fifo_flush = 1'b0; // RULE7
  assign role_slave = ctrl_reg[SSCONE_ROLE_BIT];

  // ==========================================================
  // Read data, registered
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [31:0] status_word;

  always_comb begin
    status_word = SSCONE_ZERO_WORD;
    status_word[SSCONE_ST_RUNNING_BIT] = ctrl_reg[SSCONE_ENABLE_BIT];
    status_word[SSCONE_ST_TXDRV_BIT]   = serial_tx_oe;
    status_word[SSCONE_ST_LOOP_BIT]    = ctrl_reg[SSCONE_LOOPBACK_BIT];
    status_word[SSCONE_ST_BLOCKED_BIT] = blocked_reg;
  end

  always_comb begin
    rdata_next = rdata_reg;
    if (psel && !penable && !pwrite) begin
      rdata_next = SSCONE_ZERO_WORD;
      if (hit_ctrl) begin
        rdata_next[SSCONE_CTRL_WIDTH-1:0] = ctrl_reg;
      end else if (hit_status) begin
        rdata_next = status_word;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_reg <= SSCONE_ZERO_WORD;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // Zero wait states; unmapped addresses answer with an error
  assign pready  = 1'b1;
  assign pslverr = access && !(hit_ctrl || hit_status);
  assign prdata  = rdata_reg;

endmodule

// file: tb/sscone_props.sv
// Checker: port-level properties of the serial control block
module sscone_props (
  // APB
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  // Shifter and pins
  input wire logic        shift_tx_bit,
  input wire logic        shift_tx_active,
  input wire logic        shift_rx_bit,
  input wire logic        shift_run,
  input wire logic        fifo_flush,
  input wire logic        role_slave,
  input wire logic        serial_rx_in,
  input wire logic        serial_tx_out,
  input wire logic        serial_tx_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic lb_q;
  logic sod_q;
  logic wr_ctrl;
  // Shadow fields; they only move while the port is off
  assign wr_ctrl = psel && penable && pwrite && paddr[11:2] == 10'h001 && pstrb[0];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lb_q <= 1'b0;
      sod_q <= 1'b0;
    end else if (wr_ctrl && !shift_run) begin
      lb_q <= pwdata[0];
      sod_q <= pwdata[3];
    end
  end
  // ==========================================================
  // Properties
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_en; wr_ctrl |=> shift_run == $past(pwdata[1]); endproperty
  a_en: assert property (p_en) else $error("enable bit not applied");
  property p_off; !shift_run |=> !serial_tx_oe && !serial_tx_out; endproperty
  a_off: assert property (p_off) else $error("pin active while off");
  property p_loop; lb_q |-> shift_rx_bit == shift_tx_bit; endproperty
  a_loop: assert property (p_loop) else $error("loopback path broken");
  property p_rx; !lb_q && $past(presetn, 2) |-> shift_rx_bit == $past(serial_rx_in, 2); endproperty
  a_rx: assert property (p_rx) else $error("receive pin path wrong");
  property p_out; shift_run && !lb_q |=> serial_tx_out == $past(shift_tx_bit); endproperty
  a_out: assert property (p_out) else $error("transmit pin wrong");
  property p_oe;
    shift_run && !lb_q && !(role_slave && sod_q) |=> serial_tx_oe == $past(shift_tx_active);
  endproperty
  a_oe: assert property (p_oe) else $error("pin enable wrong");
  property p_sod; role_slave && sod_q |=> !serial_tx_oe; endproperty
  a_sod: assert property (p_sod) else $error("disabled slave drives pin");
  property p_flush; $fell(shift_run) |-> !fifo_flush ##1 !fifo_flush; endproperty
  a_flush: assert property (p_flush) else $error("disable flushed fifo");
endmodule

// file: tb/sscone_peer.sv
// Peer model: serial peripheral feeding the receive pin
module sscone_peer (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic serial_tx_out,
  input  wire logic serial_tx_oe,
  output logic      serial_rx_in,
  output logic      line_level
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] phase;
  // Shared line with a pull-up: a released pin reads high, not its last value
  assign line_level = serial_tx_oe ? serial_tx_out : 1'b1;
  // Period-four pattern: a sample two cycles old is the inverse of the current bit
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase        <= 2'h0;
      serial_rx_in <= 1'b0;
    end else begin
      phase        <= phase + 2'h1;
      serial_rx_in <= phase[1];
    end
  end
endmodule

// file: tb/sync_serial_control_one_test.sv
// Testbench: register and pin scenarios of the serial control block
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module sync_serial_control_one_test import sscone_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic shift_tx_bit, shift_tx_active, shift_rx_bit, shift_run, fifo_flush;
  logic role_slave, serial_rx_in, serial_tx_out, serial_tx_oe, line_level;
  int errors = 0;
  int n_checks = 0;
  localparam logic [11:0] CT = SSCONE_OFF_CTRL1;
  localparam logic [11:0] ST = SSCONE_OFF_STATUS;
  sscone_top sscone_top_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .shift_tx_bit(shift_tx_bit), .shift_tx_active(shift_tx_active),
    .shift_rx_bit(shift_rx_bit), .shift_run(shift_run),
    .fifo_flush(fifo_flush), .role_slave(role_slave),
    .serial_rx_in(serial_rx_in), .serial_tx_out(serial_tx_out),
    .serial_tx_oe(serial_tx_oe));
  sscone_peer sscone_peer_i (.pclk(pclk), .presetn(presetn),
    .serial_tx_out(serial_tx_out), .serial_tx_oe(serial_tx_oe),
    .serial_rx_in(serial_rx_in), .line_level(line_level));
  // ==========================================================
  // Bus and closing
  task automatic end_sim;
    if (errors == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin errors++; end_sim; end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_reset;
    apb(1'b0, CT, 32'h0);
    `CHK(rd, SSCONE_ZERO_WORD)
    apb(1'b0, 12'h0fc, 32'h0);
    `CHK(er, 1'b1)
  endtask
  task automatic t_loop;
    apb(1'b1, CT, 32'h1);
    apb(1'b1, CT, 32'h3);
    for (int i = 0; i < 4; i++) begin
      @(posedge pclk); shift_tx_bit <= i[0]; shift_tx_active <= 1'b1;
      #1 `CHK(shift_rx_bit, i[0])
      `CHK(serial_tx_oe, 1'b0)
    end
    apb(1'b0, ST, 32'h0);
    `CHK(rd, 32'h5)
  endtask
  task automatic t_block;
    apb(1'b1, CT, 32'h7);
    apb(1'b0, CT, 32'h0);
    `CHK(rd, 32'h3)
    apb(1'b0, ST, 32'h0);
    `CHK(rd[3], 1'b1)
    // Clearing enable together with a field change takes only the enable
    apb(1'b1, CT, 32'h4);
    apb(1'b0, CT, 32'h0);
    `CHK(rd, 32'h1)
    // Enable is cleared alone first, then fields change
    apb(1'b1, CT, 32'h1);
    apb(1'b1, CT, 32'h0);
    apb(1'b0, ST, 32'h0);
    `CHK(rd[3], 1'b0)
    // A write without the low byte lane is ignored
    pstrb <= 4'he;
    apb(1'b1, CT, 32'h2);
    pstrb <= 4'hf;
    apb(1'b0, CT, 32'h0);
    `CHK(rd, 32'h0)
  endtask
  task automatic t_norm;
    apb(1'b1, CT, 32'h2);
    for (int i = 0; i < 4; i++) begin
      @(posedge pclk); shift_tx_bit <= i[1]; shift_tx_active <= 1'b1;
      @(posedge pclk);
      #1 `CHK(serial_tx_out, i[1])
      `CHK(serial_tx_oe, 1'b1)
      `CHK(shift_rx_bit, ~serial_rx_in)
      `CHK(line_level, i[1])
    end
    apb(1'b0, ST, 32'h0);
    `CHK(rd, 32'h3)
  endtask
  task automatic t_sod;
    apb(1'b1, CT, 32'h2);
    apb(1'b1, CT, 32'h0);
    apb(1'b1, CT, 32'hc);
    apb(1'b1, CT, 32'he);
    repeat (2) @(posedge pclk);
    #1 `CHK(serial_tx_oe, 1'b0)
    `CHK(role_slave, 1'b1)
    `CHK(line_level, 1'b1)
    apb(1'b1, CT, 32'hc);
    #1 `CHK(shift_run, 1'b0)
    `CHK(fifo_flush, 1'b0)
    // Master ignores the output disable; a slave without it drives
    apb(1'b1, CT, 32'ha);
    repeat (2) @(posedge pclk);
    #1 `CHK(serial_tx_oe, 1'b1)
    apb(1'b1, CT, 32'h8);
    apb(1'b1, CT, 32'h6);
    repeat (2) @(posedge pclk);
    #1 `CHK(serial_tx_oe, 1'b1)
    apb(1'b1, CT, 32'h4);
  endtask
  task automatic t_rst2;
    apb(1'b1, CT, 32'h2);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    #1 `CHK(serial_tx_oe, 1'b0)
    `CHK(shift_run, 1'b0)
    @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, CT, 32'h0);
    `CHK(rd, SSCONE_ZERO_WORD)
  endtask
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0; pstrb = 4'hf;
    shift_tx_bit = 1'b0; shift_tx_active = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset; t_loop; t_block; t_norm; t_sod; t_rst2;
    end_sim;
  end
endmodule
bind sscone_top sscone_props sscone_props_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .shift_tx_bit(shift_tx_bit), .shift_tx_active(shift_tx_active),
  .shift_rx_bit(shift_rx_bit), .shift_run(shift_run),
  .fifo_flush(fifo_flush), .role_slave(role_slave),
  .serial_rx_in(serial_rx_in), .serial_tx_out(serial_tx_out),
  .serial_tx_oe(serial_tx_oe));
